/* hw/bmf_fifo_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bmf_consts.svh"

// Functional notes
// - long-word width reads give the whole stored word, lanes unchanged.
// - word width: two reads on low 18 lines, endian picks half order.
// - byte width: four reads on low 9 lines, endian picks byte order.
// - upper lines above the chosen width are driven to zero during narrow reads.
// - fall-through: first word loads and output ready rises in three cycles.
// - short clock skew may add one cycle to that fall-through load.
// - output ready falls only on the last part read, not earlier parts.
// - empty flag rises after write sync, falls on the last part read.
// - input ready rises after a freeing read has crossed over.
// - full flag releases after the read of a long word's last part.
// - almost-empty rises after write sync, falls on last part read.
// - almost-full releases after the read of a long word's last part.
// - fifo read needs select low, read direction and mail select low.
// - forward mailbox keeps only the low lanes of the narrowed width.
// - reverse mailbox keeps only the low lanes of the narrowed width.
// - retransmit restarts reading at the first word since master reset.
// - per device: three read clocks to empty release, two to full.
// - endianness sampled on master reset rising edge, not for mail.
// - mailbox write drops its flag, extra writes ignored until read.
// - mailbox contents persist after read until written again.
module bmf_fifo_top #(
   parameter int DEPTH = `BMF_DEPTH,
   parameter int AE_OFFSET = `BMF_AE_OFFSET,
   parameter int AF_OFFSET = `BMF_AF_OFFSET
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic master_reset_n,
   input wire logic big_endian_select,
   input wire logic bus_match_select,
   input wire logic bus_size_byte,
   input wire logic fall_through_mode,
   input wire logic retransmit,
   input wire logic port_a_select_n,
   input wire logic port_a_direction,
   input wire logic port_a_strobe,
   input wire logic port_a_mail_select,
   input wire logic [`BMF_DATA_W-1:0] port_a_data_in,
   output logic [`BMF_DATA_W-1:0] port_a_data_out,
   output logic port_a_data_oe_n,
   input wire logic port_b_select_n,
   input wire logic port_b_direction,
   input wire logic port_b_strobe,
   input wire logic port_b_mail_select,
   input wire logic [`BMF_DATA_W-1:0] port_b_data_in,
   output logic [`BMF_DATA_W-1:0] port_b_data_out,
   output logic port_b_data_oe_n,
   output logic empty_flag_n,
   output logic output_ready,
   output logic full_flag_n,
   output logic input_ready,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic forward_mail_flag_n,
   output logic reverse_mail_flag_n
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam int DW = `BMF_DATA_W;

   // ==========================================================
   // reset release and pin synchronisers
   logic rst_n;
   logic [`BMF_PIN_W-1:0] pin_q;
   logic mrs_s, be_s, bm_s, sz_s, fall_through_mode_s, rt_s;
   logic mrs_d, rt_d, mrs_rise, rt_rise;
   logic cfg_big_endian, cfg_fall_through_mode;
   bmf_pkg::bmf_width_t width;
   logic [DW-1:0] lane_mask;

   bmf_sync #(.W(1)) u_rst_sync (
      .clk(clk),
      .arst_n(reset_n),
      .d(1'b1),
      .q(rst_n)
   );

   bmf_sync #(.W(`BMF_PIN_W)) u_pin_sync (
      .clk(clk),
      .arst_n(rst_n),
      .d({master_reset_n, big_endian_select, bus_match_select, bus_size_byte, fall_through_mode, retransmit}),
      .q(pin_q)
   );

   assign {mrs_s, be_s, bm_s, sz_s, fall_through_mode_s, rt_s} = pin_q;
   assign mrs_rise = mrs_s & ~mrs_d;
   assign rt_rise = rt_s & ~rt_d;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mrs_d <= 1'b0;
         rt_d <= 1'b0;
      end else begin
         mrs_d <= mrs_s;
         rt_d <= rt_s;
      end
   end

   // ==========================================================
   // configuration caught on master reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_big_endian <= 1'b0;
         cfg_fall_through_mode <= 1'b0;
      end else if (mrs_rise) begin
         cfg_big_endian <= be_s;
         cfg_fall_through_mode <= fall_through_mode_s;
      end
   end

   // size selects are assumed static, so they are used as levels
   always_comb begin
      if (!bm_s) begin
         width = bmf_pkg::bmf_long;
         lane_mask = '1;
      end else if (sz_s) begin
         width = bmf_pkg::bmf_byte;
         lane_mask = DW'({`BMF_BYTE_W{1'b1}});
      end else begin
         width = bmf_pkg::bmf_word;
         lane_mask = DW'({`BMF_WORD_W{1'b1}});
      end
   end

   // ==========================================================
   // storage and write port
   logic [DW-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, rel_ptr, wr_sync, rel_sync;
   logic [PW-1:0] count_a, words_b;
   logic [DW-1:0] mem_rd_word;
   logic a_fifo_wr;

   assign count_a = wr_ptr - rel_sync;
   assign words_b = wr_sync - rd_ptr;
   assign mem_rd_word = mem[rd_ptr[AW-1:0]];
   assign a_fifo_wr = mrs_s && !port_a_select_n && port_a_direction && port_a_strobe
                      && !port_a_mail_select && full_flag_n;

   always_ff @(posedge clk) begin
      if (a_fifo_wr) begin
         mem[wr_ptr[AW-1:0]] <= port_a_data_in;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
      end else if (!mrs_s) begin
         wr_ptr <= '0;
      end else if (a_fifo_wr) begin
         wr_ptr <= wr_ptr + PW'(1);
      end
   end

   // ==========================================================
   // pointer crossings; short skew shows up as one extra cycle here
   bmf_sync #(.W(PW)) u_wr_sync (
      .clk(clk),
      .arst_n(rst_n),
      .d(wr_ptr),
      .q(wr_sync)
   );

   // release pointer moves only on a long word's last part
   bmf_sync #(.W(PW)) u_rel_sync (
      .clk(clk),
      .arst_n(rst_n),
      .d(rel_ptr),
      .q(rel_sync)
   );

   // combinational from the synchronised pointer: two write-side clocks
   // held low until master reset is seen released, so no write slips in early
   assign full_flag_n = mrs_s && (count_a != PW'(DEPTH));
   assign input_ready = full_flag_n;
   assign almost_full_n = count_a < PW'(DEPTH - AF_OFFSET);

   // ==========================================================
   // read sequencing
   logic [DW-1:0] held, fifo_out, unp_word, unp_lane;
   logic [1:0] part, next_part, unp_part;
   logic held_live, next_live, part_last, pop, out_load;
   logic [PW-1:0] next_rd_ptr, next_rel_ptr;
   logic rd_req, fifo_rd;

   assign rd_req = !port_b_select_n && port_b_direction && port_b_strobe && !port_b_mail_select;
   assign fifo_rd = mrs_s && rd_req && (cfg_fall_through_mode ? held_live : empty_flag_n);

   always_comb begin
      unique case (width)
         bmf_pkg::bmf_long: part_last = 1'b1;
         bmf_pkg::bmf_word: part_last = part == 2'h1;
         bmf_pkg::bmf_byte: part_last = part == 2'h3;
      endcase
   end

   always_comb begin
      next_rd_ptr = rd_ptr;
      next_rel_ptr = rel_ptr;
      next_part = part;
      next_live = held_live;
      pop = 1'b0;
      out_load = 1'b0;
      unp_word = held;
      unp_part = part;
      if (!mrs_s) begin
         next_rd_ptr = '0;
         next_rel_ptr = '0;
         next_part = 2'h0;
         next_live = 1'b0;
      end else if (rt_rise) begin
         next_rd_ptr = '0;
         next_rel_ptr = '0;
         next_part = 2'h0;
         next_live = 1'b0;
      end else if (!cfg_fall_through_mode) begin
         if (fifo_rd) begin
            out_load = 1'b1;
            pop = part == 2'h0;
            if (pop) begin
               unp_word = mem_rd_word;
               next_rd_ptr = rd_ptr + PW'(1);
            end
            if (part_last) begin
               next_part = 2'h0;
               next_rel_ptr = rel_ptr + PW'(1);
               next_live = 1'b0;
            end else begin
               next_part = part + 2'h1;
               next_live = 1'b1;
            end
         end
      end else begin
         if (fifo_rd && part_last) begin
            next_rel_ptr = rel_ptr + PW'(1);
         end
         // fall-through: refill only once the current word is used up
         if (words_b != '0 && (!held_live || (fifo_rd && part_last))) begin
            pop = 1'b1;
            out_load = 1'b1;
            unp_word = mem_rd_word;
            unp_part = 2'h0;
            next_rd_ptr = rd_ptr + PW'(1);
            next_part = 2'h0;
            next_live = 1'b1;
         end else if (fifo_rd) begin
            if (part_last) begin
               next_part = 2'h0;
               next_live = 1'b0;
            end else begin
               out_load = 1'b1;
               unp_part = part + 2'h1;
               next_part = part + 2'h1;
            end
         end
      end
   end

   bmf_unpack u_unpack (
      .word(unp_word),
      .part(unp_part),
      .width(width),
      .big_endian(cfg_big_endian),
      .lane(unp_lane)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= '0;
         rel_ptr <= '0;
         part <= 2'h0;
         held_live <= 1'b0;
      end else begin
         rd_ptr <= next_rd_ptr;
         rel_ptr <= next_rel_ptr;
         part <= next_part;
         held_live <= next_live;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held <= '0;
         fifo_out <= '0;
      end else begin
         if (pop) begin
            held <= mem_rd_word;
         end
         if (out_load) begin
            fifo_out <= unp_lane;
         end
      end
   end

   // ==========================================================
   // read-side flags; registered, so three read clocks from a write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         empty_flag_n <= 1'b0;
         almost_empty_n <= 1'b0;
      end else begin
         empty_flag_n <= mrs_s && !rt_rise && ((wr_sync - next_rd_ptr) != '0 || next_live);
         almost_empty_n <= mrs_s && ((wr_sync - next_rel_ptr) > PW'(AE_OFFSET));
      end
   end

   assign output_ready = cfg_fall_through_mode & held_live;

   // ==========================================================
   // mailboxes
   logic [DW-1:0] forward_mailbox, reverse_mailbox;
   logic fwd_wr, fwd_rd, rev_wr, rev_rd;

   assign fwd_wr = !port_a_select_n && port_a_direction && port_a_strobe && port_a_mail_select
                   && forward_mail_flag_n;
   assign fwd_rd = !port_b_select_n && port_b_direction && port_b_strobe && port_b_mail_select;
   assign rev_wr = !port_b_select_n && !port_b_direction && port_b_strobe && port_b_mail_select
                   && reverse_mail_flag_n;
   assign rev_rd = !port_a_select_n && !port_a_direction && port_a_strobe && port_a_mail_select;

   // contents change only on an accepted write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         forward_mailbox <= '0;
         reverse_mailbox <= '0;
      end else begin
         if (fwd_wr) begin
            forward_mailbox <= port_a_data_in & lane_mask;
         end
         if (rev_wr) begin
            reverse_mailbox <= port_b_data_in & lane_mask;
         end
      end
   end

   // an accepted write in the same cycle as a read wins; a write made while mail still waits is dropped, even in the cycle of its read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         forward_mail_flag_n <= 1'b1;
         reverse_mail_flag_n <= 1'b1;
      end else begin
         if (fwd_wr) begin
            forward_mail_flag_n <= 1'b0;
         end else if (fwd_rd || !mrs_s) begin
            forward_mail_flag_n <= 1'b1;
         end
         if (rev_wr) begin
            reverse_mail_flag_n <= 1'b0;
         end else if (rev_rd || !mrs_s) begin
            reverse_mail_flag_n <= 1'b1;
         end
      end
   end

   // ==========================================================
   // output buses; endianness never applies to mail
   assign port_b_data_out = port_b_mail_select ? forward_mailbox : fifo_out;
   assign port_a_data_out = port_a_mail_select ? reverse_mailbox : '0;
   assign port_b_data_oe_n = !(!port_b_select_n && port_b_direction);
   assign port_a_data_oe_n = !(!port_a_select_n && !port_a_direction);

   // ==========================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_long_whole_word: assert property (
      (!cfg_fall_through_mode && fifo_rd && !rt_rise && width == bmf_pkg::bmf_long) |=> fifo_out == $past(mem_rd_word)
   ) else $error("long word read not passed whole");

   chk_word_half_order: assert property (
      (!cfg_fall_through_mode && fifo_rd && !rt_rise && width == bmf_pkg::bmf_word && part == 2'h0 && cfg_big_endian)
      |=> fifo_out[17:0] == $past(mem_rd_word[35:18]) ##1 $stable(held)
   ) else $error("big endian word order wrong");

   chk_byte_order: assert property (
      (!cfg_fall_through_mode && fifo_rd && !rt_rise && width == bmf_pkg::bmf_byte && part == 2'h0 && !cfg_big_endian)
      |=> fifo_out[8:0] == $past(mem_rd_word[8:0]) && part == 2'h1
   ) else $error("little endian first byte wrong");

   chk_upper_lanes: assert property (
      (width == bmf_pkg::bmf_byte && $past(out_load)) |-> fifo_out[35:9] == '0
   ) else $error("upper lanes not quiet in byte width");

   chk_fall_through: assert property (
      (cfg_fall_through_mode && mrs_s && !rt_rise && !held_live && words_b != '0) |=> held_live && output_ready
   ) else $error("fall through load missing");

   chk_ready_last_part: assert property (
      (cfg_fall_through_mode && fifo_rd && !part_last && !rt_rise && mrs_s) |=> output_ready [*1]
   ) else $error("output ready fell before last part");

   chk_empty_last_part: assert property (
      (!cfg_fall_through_mode && fifo_rd && !part_last && !rt_rise && mrs_s) |=> empty_flag_n
   ) else $error("empty flag fell before last part");

   chk_read_qualify: assert property (
      (!cfg_fall_through_mode && mrs_s && !rt_rise && (port_b_select_n || port_b_mail_select)) |=> $stable(part) && $stable(rel_ptr)
   ) else $error("fifo read taken without full qualification");

   chk_mail_flag_low: assert property (
      fwd_wr |=> !forward_mail_flag_n ##1 (!port_a_mail_select || $stable(forward_mailbox))
   ) else $error("mail flag not lowered by write");

   chk_mail_persist: assert property (
      (!fwd_wr && !rev_wr) |=> $stable(forward_mailbox) && $stable(reverse_mailbox)
   ) else $error("mailbox changed without a write");

   chk_retransmit_restart: assert property (
      (rt_rise && mrs_s) |=> rd_ptr == '0 && rel_ptr == '0 && !held_live
   ) else $error("retransmit did not restart reading");

   chk_full_release: assert property (
      (!full_flag_n && mrs_s && next_rel_ptr != rel_ptr) |-> ##3 full_flag_n
   ) else $error("full flag not released two clocks after crossing");
endmodule

`default_nettype wire

/* hw/bmf_consts.svh */
`ifndef BMF_CONSTS_SVH
`define BMF_CONSTS_SVH

// ==========================================================
// data path widths
`define BMF_DATA_W 36
`define BMF_WORD_W 18
`define BMF_BYTE_W 9

// ==========================================================
// storage and flag defaults
`define BMF_DEPTH 2048
`define BMF_AE_OFFSET 8
`define BMF_AF_OFFSET 8

// ==========================================================
// pin synchroniser bundle
`define BMF_PIN_W 6

`endif

/* hw/bmf_pkg.sv */
`default_nettype none

package bmf_pkg;
   // port b bus size, fixed while the fifo runs
   typedef enum logic [1:0] {
      bmf_long,
      bmf_word,
      bmf_byte
   } bmf_width_t;
endpackage

`default_nettype wire

/* hw/bmf_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module bmf_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // ==========================================================
   // two stages per bit; stage one feeds stage two only
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic meta;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate
endmodule

`default_nettype wire

/* hw/bmf_unpack.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bmf_consts.svh"

module bmf_unpack (
   input wire logic [`BMF_DATA_W-1:0] word,
   input wire logic [1:0] part,
   input wire bmf_pkg::bmf_width_t width,
   input wire logic big_endian,
   output logic [`BMF_DATA_W-1:0] lane
);
   logic [1:0] idx;

   // ==========================================================
   // lane select; unused upper lines are driven to zero
   always_comb begin
      lane = '0;
      idx = big_endian ? 2'h3 - part : part;
      unique case (width)
         bmf_pkg::bmf_long: begin
            lane = word;
         end
         bmf_pkg::bmf_word: begin
            if (big_endian ^ part[0]) begin
               lane[`BMF_WORD_W-1:0] = word[`BMF_DATA_W-1:`BMF_WORD_W];
            end else begin
               lane[`BMF_WORD_W-1:0] = word[`BMF_WORD_W-1:0];
            end
         end
         bmf_pkg::bmf_byte: begin
            lane[`BMF_BYTE_W-1:0] = word[idx*`BMF_BYTE_W +: `BMF_BYTE_W];
         end
      endcase
   end
endmodule

`default_nettype wire

/* testbench/bmf_producer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bmf_consts.svh"

module bmf_producer (
   input wire logic clk,
   input wire logic full_flag_n,
   output logic select_n,
   output logic direction,
   output logic strobe,
   output logic mail_select,
   output logic [`BMF_DATA_W-1:0] data
);
   // ==========================================
   // port a writer
   initial begin
      select_n = 1'b1;
      direction = 1'b0;
      strobe = 1'b0;
      mail_select = 1'b0;
      data = '0;
   end

   // entered at a falling edge; never retransmits, so no fill cap
   task automatic put(input logic mail, input logic [`BMF_DATA_W-1:0] d);
      int n;
      n = 0;
      select_n = 1'b0;
      direction = 1'b1;
      strobe = 1'b1;
      mail_select = mail;
      data = d;
      // fifo request held until room shows
      while (!mail && full_flag_n !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
   endtask

   // released lines show the inverse so stale data cannot pass
   task automatic idle();
      strobe = 1'b0;
      select_n = 1'b1;
      data = ~data;
   endtask
endmodule

`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bmf_consts.svh"

module testbench;
   logic clk = 1'b0;
   logic reset_n, master_reset_n, big_endian_select, bus_match_select, bus_size_byte, fall_through_mode;
   logic port_b_select_n, port_b_direction, port_b_strobe, port_b_mail_select, ft, retransmit;
   logic a_sel_n, a_dir, a_stb, a_mail;
   logic [`BMF_DATA_W-1:0] a_data, port_b_data_out, q;
   logic empty_flag_n, output_ready, full_flag_n, almost_empty_n, almost_full_n, forward_mail_flag_n;
   int num_errors = 0;
   int total_checks = 0;

   always #12.5 clk = ~clk;

   bmf_producer prod (.clk(clk), .full_flag_n(full_flag_n), .select_n(a_sel_n), .direction(a_dir),
      .strobe(a_stb), .mail_select(a_mail), .data(a_data));

   bmf_fifo_top #(.DEPTH(16), .AE_OFFSET(2), .AF_OFFSET(2)) DUT (.clk(clk), .reset_n(reset_n),
      .master_reset_n(master_reset_n), .big_endian_select(big_endian_select),
      .bus_match_select(bus_match_select), .bus_size_byte(bus_size_byte),
      .fall_through_mode(fall_through_mode), .retransmit(retransmit), .port_a_select_n(a_sel_n),
      .port_a_direction(a_dir), .port_a_strobe(a_stb), .port_a_mail_select(a_mail),
      .port_a_data_in(a_data), .port_a_data_out(), .port_a_data_oe_n(), .port_b_select_n(port_b_select_n),
      .port_b_direction(port_b_direction), .port_b_strobe(port_b_strobe),
      .port_b_mail_select(port_b_mail_select), .port_b_data_in('0), .port_b_data_out(port_b_data_out),
      .port_b_data_oe_n(), .empty_flag_n(empty_flag_n), .output_ready(output_ready),
      .full_flag_n(full_flag_n), .input_ready(), .almost_empty_n(almost_empty_n),
      .almost_full_n(almost_full_n), .forward_mail_flag_n(forward_mail_flag_n), .reverse_mail_flag_n());

   // ==========================================
   // helpers
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [`BMF_DATA_W-1:0] got, input logic [`BMF_DATA_W-1:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   function automatic logic flag(input int sel);
      return sel == 0 ? empty_flag_n : (sel == 1 ? output_ready : full_flag_n);
   endfunction

   // flag low two falling edges on, high on the third
   task automatic lat3(input int sel, input string what);
      repeat (2) @(negedge clk);
      chk(36'(flag(sel)), 36'h0, what);
      @(negedge clk);
      chk(36'(flag(sel)), 36'h1, what);
   endtask

   function automatic logic [`BMF_DATA_W-1:0] mk(input logic [5:0] k);
      return {3'h3, k, 3'h2, k, 3'h1, k, 3'h0, k};
   endfunction

   function automatic logic [`BMF_DATA_W-1:0] part(input logic [`BMF_DATA_W-1:0] w, input int p,
         input logic byt, input logic be);
      int i;
      i = be ? (byt ? 3 - p : 1 - p) : p;
      return byt ? 36'(w[9*i +: 9]) : 36'(w[18*i +: 18]);
   endfunction

   task automatic cfg(input logic bm, input logic byt, input logic be, input logic f);
      int n;
      n = 0;
      master_reset_n = 1'b0;
      bus_match_select = bm; // held static while running
      bus_size_byte = byt;
      big_endian_select = be;
      fall_through_mode = f;
      ft = f;
      repeat (4) @(negedge clk);
      master_reset_n = 1'b1;
      while (full_flag_n !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      big_endian_select = ~be; // later level must not matter
      fall_through_mode = ~f;
   endtask

   task automatic rd(input logic mail, output logic [`BMF_DATA_W-1:0] d);
      logic [`BMF_DATA_W-1:0] pre;
      int n;
      n = 0;
      port_b_select_n = 1'b0;
      port_b_direction = 1'b1;
      port_b_strobe = 1'b1;
      port_b_mail_select = mail;
      while (!mail && (ft ? output_ready : empty_flag_n) !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      pre = port_b_data_out;
      @(negedge clk);
      d = (ft || mail) ? pre : port_b_data_out;
   endtask

   task automatic b_idle();
      port_b_strobe = 1'b0;
      port_b_select_n = 1'b1;
      port_b_mail_select = 1'b0; // parked low, as a chained part would tie it
   endtask

   initial begin
      #(25 * 20000);
      num_errors++;
      $display("watchdog expired");
      test_done();
   end

   // ==========================================
   // tests
   initial begin
      reset_n = 1'b0;
      master_reset_n = 1'b0;
      big_endian_select = 1'b0;
      bus_match_select = 1'b0;
      bus_size_byte = 1'b0;
      fall_through_mode = 1'b0;
      ft = 1'b0;
      retransmit = 1'b0;
      b_idle();
      port_b_direction = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      cfg(0, 0, 0, 0);
      prod.put(0, mk(1));
      prod.idle();
      lat3(0, "empty release");
      prod.put(0, mk(2));
      prod.idle();
      for (int v = 0; v < 2; v++) begin
         port_b_select_n = v[0] ? 1'b0 : 1'b1;
         port_b_direction = ~v[0];
         port_b_strobe = 1'b1;
         @(negedge clk);
         b_idle();
         @(negedge clk);
      end
      rd(0, q);
      chk(q, mk(1), "long word 1");
      rd(0, q);
      chk(q, mk(2), "long word 2");
      b_idle();
      chk(36'(empty_flag_n), 36'h0, "empty after last");
      retransmit = 1'b1;
      repeat (4) @(negedge clk);
      retransmit = 1'b0;
      rd(0, q); // waits for empty flag high first
      chk(q, mk(1), "retransmit first word");
      b_idle();
      $display("test long done");
      for (int m = 0; m < 4; m++) begin
         cfg(1, m[1], m[0], 0);
         prod.put(0, mk(6'(10 + m)));
         prod.put(0, mk(6'(20 + m)));
         prod.idle();
         repeat (4) @(negedge clk);
         for (int k = 0; k < 2; k++) begin
            for (int p = 0; p < (m[1] ? 4 : 2); p++) begin
               rd(0, q);
               chk(q, part(mk(6'(10 * k + 10 + m)), p, m[1], m[0]), "narrow part");
               chk(36'(empty_flag_n), 36'(!(k == 1 && p == (m[1] ? 3 : 1))), "empty per part");
            end
         end
         b_idle();
      end
      $display("test narrow done");
      cfg(1, 1, 1, 1);
      prod.put(0, mk(6));
      prod.idle();
      lat3(1, "fall through");
      for (int p = 0; p < 4; p++) begin
         rd(0, q);
         chk(q, part(mk(6), p, 1, 1), "fall through part");
         chk(36'(output_ready), 36'(p < 3), "ready per part");
      end
      b_idle();
      $display("test fall through done");
      cfg(1, 0, 1, 0);
      for (int k = 0; k < 16; k++) prod.put(0, mk(6'(k)));
      prod.idle();
      repeat (4) @(negedge clk);
      chk(36'(full_flag_n), 36'h0, "full");
      chk(36'(almost_full_n), 36'h0, "almost full");
      chk(36'(almost_empty_n), 36'h1, "not almost empty");
      rd(0, q);
      b_idle();
      repeat (4) @(negedge clk);
      chk(36'(full_flag_n), 36'h0, "full after first part");
      rd(0, q);
      b_idle();
      @(negedge clk);
      chk(36'(full_flag_n), 36'h0, "full release early");
      @(negedge clk);
      chk(36'(full_flag_n), 36'h1, "full release");
      for (int k = 1; k < 16; k++) begin
         rd(0, q);
         chk(q, part(mk(6'(k)), 0, 0, 1), "drain upper");
         rd(0, q);
         chk(q, part(mk(6'(k)), 1, 0, 1), "drain lower");
      end
      b_idle();
      repeat (4) @(negedge clk);
      chk(36'(almost_empty_n), 36'h0, "almost empty");
      chk(36'(almost_full_n), 36'h1, "almost full off");
      $display("test fill done");
      prod.put(1, '1);
      prod.idle();
      @(negedge clk);
      chk(36'(forward_mail_flag_n), 36'h0, "mail flag low");
      prod.put(1, '0);
      prod.idle();
      port_b_mail_select = 1'b1;
      @(negedge clk);
      chk(port_b_data_out, 36'h00003ffff, "mail lanes");
      rd(1, q);
      b_idle();
      @(negedge clk);
      chk(36'(forward_mail_flag_n), 36'h1, "mail flag high");
      port_b_mail_select = 1'b1;
      @(negedge clk);
      chk(port_b_data_out, 36'h00003ffff, "mail kept");
      b_idle();
      $display("test mailbox done");
      test_done();
   end
endmodule

`default_nettype wire
